// ==== rtl/bode_consts.svh ====
// Register offsets, field positions, reset values and fixed addresses of the byte-op unit
`ifndef BODE_CONSTS_SVH
`define BODE_CONSTS_SVH
`define BODE_OFF_CTRL      8'h00
`define BODE_OFF_ACC       8'h04
`define BODE_OFF_STATUS    8'h08
`define BODE_OFF_BANK_SELECT 8'h0c
`define BODE_OFF_IDX       8'h10
`define BODE_OFF_PROD      8'h14
`define BODE_OFF_STATE     8'h18
`define BODE_CTRL_RUN      0
`define BODE_CTRL_EXT      1
`define BODE_CTRL_PSC      2
`define BODE_FLG_C         0
`define BODE_FLG_DIGIT_CARRY 1
`define BODE_FLG_Z         2
`define BODE_FLG_SIGNED_RANGE 3
`define BODE_FLG_N         4
`define BODE_CTRL_RST      3'h0
`define BODE_ACC_RST       8'h00
`define BODE_FLAGS_RST     5'h00
`define BODE_BANK_SELECT_RST 4'h0
`define BODE_IDX_RST       12'h000
`define BODE_WIN_HI_BANK   4'hf
`define BODE_WIN_LO_BANK   4'h0
`define BODE_IDX_LIMIT     8'h5f
`define BODE_PORT_ADDR     12'hf80
`define BODE_TMR_ADDR      12'hfd6
`define BODE_MOVE_HI       4'hc
`define BODE_SECOND_HI     4'hf
`define BODE_LAST_Q        2'h3
`endif

// ==== rtl/bode_core.sv ====
// Byte-oriented instruction decode and execute unit with APB control registers
`timescale 1ns/1ps
`include "bode_consts.svh"

// Notes on behaviour
// - Add with carry sums accumulator, file byte, carry; updates all five status flags.
// - Destination bit 0 writes accumulator; 1 writes back to the file byte.
// - Bank bit 0 uses the fixed window; 1 takes upper bits from bank select.
// - Bank bit 0 with extended set and address up to 95 uses indexed offset.
// - Compare-skip on equal, greater, less versus accumulator; no flags changed.
// - A true test or changed flow costs a second, empty instruction cycle.
// - A lone second word runs as no-operation; the first word consumes it.
// - File-to-file move: two words, two cycles, twelve-bit addresses, no flags.
// - Read-modify of the port register reads the pin levels, not the latch.
// - Writing the timer zero count clears its prescaler when assigned.
// - Decrement-skip writes destination, skips on zero or nonzero; no flags.
// - Increment-skip writes destination, skips on zero or nonzero; no flags.
// - Rotates through carry use carry as ninth bit; update C, Z, N.
// - Plain rotates circulate eight bits; update only Z and N.
// - OR, XOR and AND with accumulator update only Z and N.
// - Subtract with borrow, either order; updates all five status flags.
// - Multiply accumulator by file byte in one cycle; no flags changed.
// - Literal minus accumulator in two's complement; carry set when not negative.
module bode_core (
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic [15:0] instr_word,
  input  wire logic        instr_valid,
  output logic             instr_ready,
  output logic      [11:0] mem_addr,
  output logic      [7:0]  mem_wdata,
  output logic             mem_we,
  input  wire logic [7:0]  mem_rdata,
  input  wire logic [7:0]  pin_levels,
  output logic             prescaler_clear
);

  bode_pkg::bode_regs_t r_ff;
  bode_pkg::bode_regs_t nxt_r;

  // Adder shared by add, subtract, increment, decrement and negate:
  // {overflow, digit carry, carry, sum}
  function automatic logic [10:0] add8(input logic [7:0] a, input logic [7:0] b,
                                       input logic cin);
    logic [8:0] s;
    logic [4:0] lo;
    logic       ovf;
    s   = {1'b0, a} + {1'b0, b} + {8'h00, cin};
    lo  = {1'b0, a[3:0]} + {1'b0, b[3:0]} + {4'h0, cin};
    ovf = (a[7] == b[7]) && (s[7] != a[7]);
    return {ovf, lo[4], s[8], s[7:0]};
  endfunction : add8

  // Effective data address from the file field and bank bit
  function automatic logic [11:0] eff_addr(input logic [15:0] w, input logic [3:0] bank_sel,
                                           input logic ext, input logic [11:0] idx);
    logic [11:0] ea;
    if (w[8])
      ea = {bank_sel, w[7:0]};
    else if (ext && (w[7:0] <= `BODE_IDX_LIMIT))
      ea = idx + {4'h0, w[7:0]};
    else if (w[7])
      ea = {`BODE_WIN_HI_BANK, w[7:0]};
    else
      ea = {`BODE_WIN_LO_BANK, w[7:0]};
    return ea;
  endfunction : eff_addr

  bode_pkg::bode_op_t op;
  logic        d_bit;
  logic [7:0]  f;
  logic [7:0]  w;
  logic [7:0]  k;
  logic        cy;
  logic [10:0] sum;
  logic [7:0]  dres;
  logic [4:0]  dflg;
  logic [4:0]  fmask;
  logic        to_acc;
  logic        to_file;
  logic        dcond;
  logic        is_mul;
  logic        is_move;
  logic        is_second;
  logic        apb_wr;
  logic        mapped;
  logic        fetch_take;

  assign op        = bode_pkg::bode_op_t'(r_ff.ir[15:10]);
  assign d_bit     = r_ff.ir[9];
  assign f         = r_ff.opnd;
  assign w         = r_ff.acc;
  assign k         = r_ff.ir[7:0];
  assign cy        = r_ff.flags[`BODE_FLG_C];
  assign is_move   = (r_ff.ir[15:12] == `BODE_MOVE_HI);
  assign is_second = (r_ff.ir[15:12] == `BODE_SECOND_HI);

  // Operation decode: result, new flags, flag mask, destination and skip test
  always_comb
  begin
    sum     = 11'h000;
    dres    = 8'h00;
    fmask   = 5'h00;
    to_acc  = 1'b0;
    to_file = 1'b0;
    dcond   = 1'b0;
    is_mul  = 1'b0;
    dflg    = 5'h00;
    unique case (op)
      bode_pkg::OP_MUL_GRP:  is_mul = d_bit;
      bode_pkg::OP_DEC:      begin sum = add8(f, 8'hfe, 1'b1); fmask = 5'h1f; end
      bode_pkg::OP_LIT_GRP:
      begin
        if (r_ff.ir[9:8] == 2'b00)
        begin
          sum    = add8(k, ~w, 1'b1);
          fmask  = 5'h1f;
          to_acc = 1'b1;
        end
        else if (r_ff.ir[9:8] == 2'b11)
        begin
          dres   = w & k;
          fmask  = 5'h14;
          to_acc = 1'b1;
        end
      end
      bode_pkg::OP_IOR:      begin dres = w | f; fmask = 5'h14; end
      bode_pkg::OP_AND:      begin dres = w & f; fmask = 5'h14; end
      bode_pkg::OP_XOR:      begin dres = w ^ f; fmask = 5'h14; end
      bode_pkg::OP_COMP:     begin dres = ~f; fmask = 5'h14; end
      bode_pkg::OP_ADDC:     begin sum = add8(w, f, cy); fmask = 5'h1f; end
      bode_pkg::OP_ADD:      begin sum = add8(w, f, 1'b0); fmask = 5'h1f; end
      bode_pkg::OP_INC:      begin sum = add8(f, 8'h01, 1'b0); fmask = 5'h1f; end
      bode_pkg::OP_DEC_SZ:   sum = add8(f, 8'hfe, 1'b1);
      bode_pkg::OP_DEC_SNZ:  sum = add8(f, 8'hfe, 1'b1);
      bode_pkg::OP_INC_SZ:   sum = add8(f, 8'h01, 1'b0);
      bode_pkg::OP_INC_SNZ:  sum = add8(f, 8'h01, 1'b0);
      bode_pkg::OP_RR_C:
      begin
        dres = {cy, f[7:1]};
        dflg[`BODE_FLG_C] = f[0];
        fmask = 5'h15;
      end
      bode_pkg::OP_RL_C:
      begin
        dres = {f[6:0], cy};
        dflg[`BODE_FLG_C] = f[7];
        fmask = 5'h15;
      end
      bode_pkg::OP_SWAP:     dres = {f[3:0], f[7:4]};
      bode_pkg::OP_RR_PLAIN: begin dres = {f[0], f[7:1]}; fmask = 5'h14; end
      bode_pkg::OP_RL_PLAIN: begin dres = {f[6:0], f[7]}; fmask = 5'h14; end
      bode_pkg::OP_COPY:     begin dres = f; fmask = 5'h14; end
      bode_pkg::OP_AMF_B:    begin sum = add8(w, ~f, cy); fmask = 5'h1f; end
      bode_pkg::OP_FMA_B:    begin sum = add8(f, ~w, cy); fmask = 5'h1f; end
      bode_pkg::OP_FMA:      begin sum = add8(f, ~w, 1'b1); fmask = 5'h1f; end
      bode_pkg::OP_CMP_A:    dcond = d_bit ? (f == w) : (f < w);
      bode_pkg::OP_CMP_B:    dcond = d_bit ? (f == 8'h00) : (f > w);
      bode_pkg::OP_FILL_GRP:
      begin
        to_file = 1'b1;
        dres    = d_bit ? 8'h00 : 8'hff;
        fmask   = d_bit ? 5'h04 : 5'h00;
        dflg[`BODE_FLG_Z] = d_bit;
      end
      bode_pkg::OP_NEG_GRP:
      begin
        to_file = 1'b1;
        if (d_bit)
          dres = w;
        else
        begin
          sum   = add8(8'h00, ~f, 1'b1);
          fmask = 5'h1f;
        end
      end
      default:               dres = 8'h00;
    endcase
    if (sum != 11'h000 || fmask == 5'h1f)
    begin
      dres = sum[7:0];
      dflg[`BODE_FLG_C]  = sum[8];
      dflg[`BODE_FLG_DIGIT_CARRY]  = sum[9];
      dflg[`BODE_FLG_SIGNED_RANGE] = sum[10];
    end
    dflg[`BODE_FLG_Z] = dflg[`BODE_FLG_Z] | (dres == 8'h00);
    dflg[`BODE_FLG_N] = dres[7];
    if (op == bode_pkg::OP_DEC_SZ || op == bode_pkg::OP_INC_SZ)
      dcond = (dres == 8'h00);
    if (op == bode_pkg::OP_DEC_SNZ || op == bode_pkg::OP_INC_SNZ)
      dcond = (dres != 8'h00);
    // Swap leaves no flag or sum trace, so a zero result must still be routed
    if (!to_file && !to_acc
        && (fmask != 5'h00 || sum != 11'h000 || dres != 8'h00 || op == bode_pkg::OP_SWAP)
        && op != bode_pkg::OP_CMP_A && op != bode_pkg::OP_CMP_B && op != bode_pkg::OP_MUL_GRP)
    begin
      to_acc  = !d_bit;
      to_file = d_bit;
    end
    if (op == bode_pkg::OP_MUL_GRP || op == bode_pkg::OP_CMP_A || op == bode_pkg::OP_CMP_B
        || r_ff.ir[15:14] != 2'b00 && r_ff.ir[15:13] != 3'b010 && r_ff.ir[15:12] != 4'h6)
    begin
      to_acc  = 1'b0;
      to_file = 1'b0;
      fmask   = 5'h00;
    end
  end

  assign instr_ready = ((r_ff.st == bode_pkg::S_FETCH) || (r_ff.st == bode_pkg::S_MOVE_WAIT))
                       && r_ff.ctrl[`BODE_CTRL_RUN];
  assign fetch_take  = instr_ready && instr_valid;
  assign apb_wr      = psel && penable && pwrite;
  assign mapped      = (paddr == `BODE_OFF_CTRL) || (paddr == `BODE_OFF_ACC) ||
                       (paddr == `BODE_OFF_STATUS) || (paddr == `BODE_OFF_BANK_SELECT) ||
                       (paddr == `BODE_OFF_IDX) || (paddr == `BODE_OFF_PROD) ||
                       (paddr == `BODE_OFF_STATE);

  always_comb
  begin
    nxt_r         = r_ff;
    nxt_r.we      = 1'b0;
    nxt_r.psc_clr = 1'b0;
    // Software writes first, so a same-cycle update by the core wins
    if (apb_wr)
    begin
      unique case (paddr)
        `BODE_OFF_CTRL:   nxt_r.ctrl  = pwdata[2:0];
        `BODE_OFF_ACC:    nxt_r.acc   = pwdata[7:0];
        `BODE_OFF_STATUS: nxt_r.flags = pwdata[4:0];
        `BODE_OFF_BANK_SELECT: nxt_r.bank_select_register = pwdata[3:0];
        `BODE_OFF_IDX:    nxt_r.idx   = pwdata[11:0];
        default:          nxt_r.ctrl  = nxt_r.ctrl;
      endcase
    end
    if (psel && !penable)
    begin
      unique case (paddr)
        `BODE_OFF_CTRL:   nxt_r.prdata = {29'h0, r_ff.ctrl};
        `BODE_OFF_ACC:    nxt_r.prdata = {24'h0, r_ff.acc};
        `BODE_OFF_STATUS: nxt_r.prdata = {27'h0, r_ff.flags};
        `BODE_OFF_BANK_SELECT: nxt_r.prdata = {28'h0, r_ff.bank_select_register};
        `BODE_OFF_IDX:    nxt_r.prdata = {20'h0, r_ff.idx};
        `BODE_OFF_PROD:   nxt_r.prdata = {16'h0, r_ff.prod};
        `BODE_OFF_STATE:  nxt_r.prdata = {11'h0, r_ff.skip, r_ff.st, r_ff.ir};
        default:          nxt_r.prdata = 32'h0;
      endcase
    end
    unique case (r_ff.st)
      bode_pkg::S_FETCH:
      begin
        nxt_r.q = 2'h0;
        if (fetch_take)
        begin
          nxt_r.ir = instr_word;
          if (r_ff.skip != 2'h0)
          begin
            // Discarded word; a skipped move also drags its second word along
            nxt_r.st   = bode_pkg::S_NOP;
            nxt_r.skip = (instr_word[15:12] == `BODE_MOVE_HI) ? 2'h1 : 2'h0;
          end
          else if (instr_word[15:12] == `BODE_SECOND_HI)
            nxt_r.st = bode_pkg::S_NOP;
          else
            nxt_r.st = bode_pkg::S_EXEC;
        end
      end
      bode_pkg::S_NOP:
      begin
        nxt_r.q = r_ff.q + 2'h1;
        if (r_ff.q == `BODE_LAST_Q)
          nxt_r.st = bode_pkg::S_FETCH;
      end
      bode_pkg::S_EXEC:
      begin
        nxt_r.q = r_ff.q + 2'h1;
        unique case (r_ff.q)
          2'h0:
            nxt_r.addr = is_move ? r_ff.ir[11:0]
                       : eff_addr(r_ff.ir, r_ff.bank_select_register,
                                  r_ff.ctrl[`BODE_CTRL_EXT], r_ff.idx);
          2'h1:
            nxt_r.opnd = (r_ff.addr == `BODE_PORT_ADDR) ? pin_levels : mem_rdata;
          2'h2:
          begin
            nxt_r.res    = dres;
            nxt_r.rflags = (r_ff.flags & ~fmask) | (dflg & fmask);
            nxt_r.cond   = dcond;
          end
          default:
          begin
            if (is_move)
              nxt_r.st = bode_pkg::S_MOVE_WAIT;
            else
              nxt_r.st = bode_pkg::S_FETCH;
            if (is_mul)
              nxt_r.prod = {8'h00, w} * {8'h00, f};
            nxt_r.flags = r_ff.rflags;
            if (to_acc)
              nxt_r.acc = r_ff.res;
            if (to_file)
            begin
              nxt_r.we    = 1'b1;
              nxt_r.wdata = r_ff.res;
              nxt_r.psc_clr = (r_ff.addr == `BODE_TMR_ADDR) && r_ff.ctrl[`BODE_CTRL_PSC];
            end
            if (r_ff.cond)
              nxt_r.skip = 2'h1;
          end
        endcase
      end
      bode_pkg::S_MOVE_WAIT:
      begin
        nxt_r.q = 2'h0;
        if (fetch_take)
        begin
          nxt_r.dst = instr_word[11:0];
          nxt_r.st  = bode_pkg::S_MOVE_WR;
        end
      end
      bode_pkg::S_MOVE_WR:
      begin
        nxt_r.q = r_ff.q + 2'h1;
        if (r_ff.q == 2'h0)
          nxt_r.addr = r_ff.dst;
        if (r_ff.q == `BODE_LAST_Q)
        begin
          nxt_r.st      = bode_pkg::S_FETCH;
          nxt_r.we      = 1'b1;
          nxt_r.wdata   = r_ff.opnd;
          nxt_r.psc_clr = (r_ff.dst == `BODE_TMR_ADDR) && r_ff.ctrl[`BODE_CTRL_PSC];
        end
      end
      default:
        nxt_r.st = bode_pkg::S_FETCH;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      r_ff        <= '0;
      r_ff.st     <= bode_pkg::S_FETCH;
      r_ff.ctrl   <= `BODE_CTRL_RST;
      r_ff.acc    <= `BODE_ACC_RST;
      r_ff.flags  <= `BODE_FLAGS_RST;
      r_ff.bank_select_register <= `BODE_BANK_SELECT_RST;
      r_ff.idx    <= `BODE_IDX_RST;
    end
    else
      r_ff <= nxt_r;
  end

  assign prdata          = r_ff.prdata;
  assign pready          = 1'b1;
  assign pslverr         = psel && penable && !mapped;
  assign mem_addr        = r_ff.addr;
  assign mem_wdata       = r_ff.wdata;
  assign mem_we          = r_ff.we;
  assign prescaler_clear = r_ff.psc_clr;

endmodule : bode_core

// ==== rtl/bode_pkg.sv ====
// Types of the byte-op decode and execute unit
package bode_pkg;
  typedef enum logic [2:0] {
    S_FETCH     = 3'b000,
    S_EXEC      = 3'b001,
    S_NOP       = 3'b010,
    S_MOVE_WAIT = 3'b011,
    S_MOVE_WR   = 3'b100
  } bode_state_t;

  typedef enum logic [5:0] {
    OP_MUL_GRP   = 6'b000000,
    OP_DEC       = 6'b000001,
    OP_LIT_GRP   = 6'b000010,
    OP_IOR       = 6'b000100,
    OP_AND       = 6'b000101,
    OP_XOR       = 6'b000110,
    OP_COMP      = 6'b000111,
    OP_ADDC      = 6'b001000,
    OP_ADD       = 6'b001001,
    OP_INC       = 6'b001010,
    OP_DEC_SZ    = 6'b001011,
    OP_RR_C      = 6'b001100,
    OP_RL_C      = 6'b001101,
    OP_SWAP      = 6'b001110,
    OP_INC_SZ    = 6'b001111,
    OP_RR_PLAIN  = 6'b010000,
    OP_RL_PLAIN  = 6'b010001,
    OP_INC_SNZ   = 6'b010010,
    OP_DEC_SNZ   = 6'b010011,
    OP_COPY      = 6'b010100,
    OP_AMF_B     = 6'b010101,
    OP_FMA_B     = 6'b010110,
    OP_FMA       = 6'b010111,
    OP_CMP_A     = 6'b011000,
    OP_CMP_B     = 6'b011001,
    OP_FILL_GRP  = 6'b011010,
    OP_NEG_GRP   = 6'b011011
  } bode_op_t;

  typedef struct packed {
    bode_state_t st;
    logic [1:0]  q;
    logic [15:0] ir;
    logic [7:0]  acc;
    logic [4:0]  flags;
    logic [3:0]  bank_select_register;
    logic [2:0]  ctrl;
    logic [11:0] idx;
    logic [15:0] prod;
    logic [11:0] addr;
    logic [11:0] dst;
    logic [7:0]  opnd;
    logic [7:0]  res;
    logic [4:0]  rflags;
    logic        cond;
    logic [1:0]  skip;
    logic [7:0]  wdata;
    logic        we;
    logic        psc_clr;
    logic [31:0] prdata;
  } bode_regs_t;
endpackage : bode_pkg

// ==== test/bode_core_monitor.sv ====
// Port-level assertions for the byte-op decode and execute unit
`timescale 1ns/1ps
`include "bode_consts.svh"
module bode_core_monitor (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic [15:0] instr_word,
  input wire logic        instr_valid,
  input wire logic        instr_ready,
  input wire logic [11:0] mem_addr,
  input wire logic        mem_we,
  input wire logic        prescaler_clear
);
  logic        take;
  logic [11:0] dst_ff;

  assign take = instr_valid && instr_ready;

  // Low bits of the last word taken, the destination of a move second word
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      dst_ff <= 12'h000;
    else if (take)
      dst_ff <= instr_word[11:0];

  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence s_move_first;
    take && instr_word[15:12] == `BODE_MOVE_HI;
  endsequence
  sequence s_move_pair;
    s_move_first ##[1:8] (take && instr_word[15:12] == `BODE_SECOND_HI);
  endsequence

  chk_ready_low: assert property (take |=> !instr_ready [*4])
    else $error("instr_ready high during execute quarters");
  chk_we_pulse: assert property (mem_we |=> !mem_we)
    else $error("mem_we longer than one cycle");
  chk_we_after_q3: assert property (mem_we |-> !$past(instr_ready))
    else $error("file write not after fourth quarter");
  chk_psc_timer: assert property (prescaler_clear |-> mem_we && mem_addr == `BODE_TMR_ADDR)
    else $error("prescaler clear without timer write");
  chk_cmp_quiet: assert property (take && instr_word[15:11] == 5'b01100 |=> !mem_we [*6])
    else $error("compare wrote the file");
  chk_mul_quiet: assert property (take && instr_word[15:9] == 7'b0000001 |=> !mem_we [*6])
    else $error("multiply wrote the file");
  chk_move_quiet: assert property (s_move_first |=> !mem_we [*4])
    else $error("move first word wrote the file");
  chk_move_dest: assert property (s_move_pair |-> ##1 (!mem_we || mem_addr == dst_ff) [*6])
    else $error("move wrote outside its destination");
endmodule : bode_core_monitor

bind bode_core bode_core_monitor u_mon (
  .pclk(pclk), .presetn(presetn), .instr_word(instr_word), .instr_valid(instr_valid),
  .instr_ready(instr_ready), .mem_addr(mem_addr), .mem_we(mem_we),
  .prescaler_clear(prescaler_clear)
);

// ==== test/bode_dmem.sv ====
// Data memory model answering the unit's file reads and writes
`timescale 1ns/1ps
module bode_dmem (
  input  wire logic        pclk,
  input  wire logic [11:0] mem_addr,
  input  wire logic [7:0]  mem_wdata,
  input  wire logic        mem_we,
  output logic      [7:0]  mem_rdata
);
  logic [7:0] mem [0:4095];

  // Combinational read, the unit samples it late in the cycle
  assign mem_rdata = mem[mem_addr];

  always @(posedge pclk)
    if (mem_we)
      mem[mem_addr] <= mem_wdata;
endmodule : bode_dmem

// ==== test/tb_byte_op_decode_execute.sv ====
// Self-checking bench for the byte-op decode and execute unit
`timescale 1ns/1ps
`include "bode_consts.svh"
module tb_byte_op_decode_execute;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [7:0]  paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [15:0] instr_word;
  logic        instr_valid;
  logic        instr_ready;
  logic [11:0] mem_addr;
  logic [7:0]  mem_wdata;
  logic        mem_we;
  logic [7:0]  mem_rdata;
  logic [7:0]  pin_levels;
  logic        prescaler_clear;
  logic [20:0] exp_q[$];
  int          error_cnt;
  int          n_checks;
  logic [31:0] rd;
  logic        serr;
  logic [7:0]  ra;
  logic [7:0]  rf;
  logic [7:0]  rr;
  logic [1:0]  sel;

  bode_core u_dut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .instr_word(instr_word), .instr_valid(instr_valid), .instr_ready(instr_ready),
    .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_we(mem_we), .mem_rdata(mem_rdata),
    .pin_levels(pin_levels), .prescaler_clear(prescaler_clear));
  bode_dmem u_mem (.pclk(pclk), .mem_addr(mem_addr), .mem_wdata(mem_wdata),
    .mem_we(mem_we), .mem_rdata(mem_rdata));

  initial
  begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask : chk

  task stop_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  task tmo;
    error_cnt++;
    $display("[ERR] %0t wait ran out", $time);
    stop_test;
  endtask : tmo

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      tmo;
    rd = prdata;
    serr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  // Offers a word and returns just after the edge that takes it
  task exec(input logic [15:0] w);
    int n;
    n = 0;
    instr_word <= w;
    instr_valid <= 1'b1;
    @(negedge pclk);
    while (instr_ready !== 1'b1 && n < 40)
    begin
      @(negedge pclk);
      n++;
    end
    if (n >= 40)
      tmo;
    @(posedge pclk);
  endtask : exec

  task idle(input int k);
    instr_valid <= 1'b0;
    repeat (k) @(posedge pclk);
  endtask : idle

  // One operation on file 0x240, then a move 0x241 to 0x242 that a skip must discard
  task run(input logic [7:0] op, input logic [7:0] a, input logic [7:0] f,
           input logic [4:0] si, input logic [7:0] r, input logic dw, input logic sk,
           input logic [4:0] so);
    u_mem.mem[12'h240] = f;
    u_mem.mem[12'h241] = 8'h5a;
    apb(1'b1, `BODE_OFF_ACC, {24'h0, a});
    apb(1'b1, `BODE_OFF_STATUS, {27'h0, si});
    if (dw)
      exp_q.push_back({1'b0, 12'h240, r});
    if (!sk)
      exp_q.push_back({1'b0, 12'h242, 8'h5a});
    exec({op, 8'h40});
    exec(16'hc241);
    exec(16'hf242);
    idle(16);
    apb(1'b0, `BODE_OFF_STATUS, 32'h0);
    chk(rd, {27'h0, so});
    apb(1'b0, `BODE_OFF_ACC, 32'h0);
    chk(rd, {24'h0, dw ? a : r});
  endtask : run

  always @(posedge pclk)
    if (presetn === 1'b1 && mem_we === 1'b1)
    begin
      if (exp_q.size() == 0)
        chk({20'h0, mem_addr}, 32'hfffff);
      else
        chk({11'h0, prescaler_clear, mem_addr, mem_wdata}, {11'h0, exp_q.pop_front()});
    end

  initial
  begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    instr_word = 16'h0000;
    instr_valid = 1'b0;
    pin_levels = 8'h00;
    error_cnt = 0;
    n_checks = 0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    void'($urandom(29912));
    for (int i = 0; i < 5; i++)
    begin
      apb(1'b0, 8'(i * 4), 32'h0);
      chk(rd, 32'h0);
    end
    apb(1'b0, 8'h1c, 32'h0);
    chk({31'h0, serr}, 32'h1);
    $display("test registers done");
    apb(1'b1, `BODE_OFF_BANK_SELECT, 32'h2);
    apb(1'b1, `BODE_OFF_CTRL, 32'h1);
    run(8'h23, 8'h4d, 8'h02, 5'h01, 8'h50, 1'b1, 1'b0, 5'h02);
    run(8'h21, 8'h7f, 8'h00, 5'h01, 8'h80, 1'b0, 1'b0, 5'h1a);
    run(8'h39, 8'h55, 8'h00, 5'h0a, 8'h00, 1'b0, 1'b0, 5'h0a);
    run(8'h2f, 8'h00, 8'h01, 5'h15, 8'h00, 1'b1, 1'b1, 5'h15);
    run(8'h4f, 8'h00, 8'h01, 5'h15, 8'h00, 1'b1, 1'b0, 5'h15);
    run(8'h3f, 8'h00, 8'hff, 5'h0a, 8'h00, 1'b1, 1'b1, 5'h0a);
    run(8'h4b, 8'h00, 8'h05, 5'h0a, 8'h06, 1'b1, 1'b1, 5'h0a);
    run(8'h63, 8'h33, 8'h33, 5'h0a, 8'h33, 1'b0, 1'b1, 5'h0a);
    run(8'h65, 8'h10, 8'h20, 5'h0a, 8'h10, 1'b0, 1'b1, 5'h0a);
    run(8'h61, 8'h20, 8'h10, 5'h0a, 8'h20, 1'b0, 1'b1, 5'h0a);
    run(8'h61, 8'h10, 8'h20, 5'h0a, 8'h10, 1'b0, 1'b0, 5'h0a);
    run(8'h37, 8'h00, 8'h81, 5'h01, 8'h03, 1'b1, 1'b0, 5'h01);
    run(8'h33, 8'h00, 8'h01, 5'h00, 8'h00, 1'b1, 1'b0, 5'h05);
    run(8'h47, 8'h00, 8'h81, 5'h13, 8'h03, 1'b1, 1'b0, 5'h03);
    run(8'h43, 8'h00, 8'h01, 5'h04, 8'h80, 1'b1, 1'b0, 5'h10);
    run(8'h5b, 8'h01, 8'h03, 5'h01, 8'h02, 1'b1, 1'b0, 5'h03);
    run(8'h57, 8'h01, 8'h01, 5'h00, 8'hff, 1'b1, 1'b0, 5'h10);
    run(8'h08, 8'h40, 8'h00, 5'h00, 8'h00, 1'b0, 1'b0, 5'h07);
    run(8'h08, 8'h41, 8'h00, 5'h00, 8'hff, 1'b0, 1'b0, 5'h10);
    run(8'h03, 8'h10, 8'h12, 5'h0b, 8'h10, 1'b0, 1'b0, 5'h0b);
    apb(1'b0, `BODE_OFF_PROD, 32'h0);
    chk(rd, 32'h120);
    $display("test table done");
    for (int i = 0; i < 6; i++)
    begin
      ra = 8'($urandom);
      rf = 8'($urandom);
      sel = 2'(i % 3);
      rr = sel == 2'h0 ? (ra | rf) : sel == 2'h1 ? (ra & rf) : (ra ^ rf);
      run(sel == 2'h0 ? 8'h13 : sel == 2'h1 ? 8'h17 : 8'h1b, ra, rf, 5'h03, rr, 1'b1, 1'b0,
          {rr[7], 1'b0, rr == 8'h00, 2'h3});
    end
    $display("test logic done");
    exec(16'hf240);
    idle(8);
    apb(1'b1, `BODE_OFF_ACC, 32'h0);
    apb(1'b1, `BODE_OFF_CTRL, 32'h5);
    u_mem.mem[`BODE_PORT_ADDR] = 8'h00;
    rf = 8'($urandom) | 8'h01;
    pin_levels <= rf;
    exp_q.push_back({1'b0, `BODE_PORT_ADDR, rf});
    exec(16'h1a80);
    idle(8);
    u_mem.mem[`BODE_TMR_ADDR] = 8'h0f;
    exp_q.push_back({1'b1, `BODE_TMR_ADDR, 8'h0f});
    exec(16'h1ad6);
    idle(8);
    apb(1'b1, `BODE_OFF_CTRL, 32'h3);
    apb(1'b1, `BODE_OFF_IDX, 32'h300);
    u_mem.mem[12'h310] = 8'h3c;
    exp_q.push_back({1'b0, 12'h310, 8'h3c});
    exec(16'h1a10);
    u_mem.mem[12'h060] = 8'h66;
    exp_q.push_back({1'b0, 12'h060, 8'h66});
    exec(16'h1a60);
    idle(12);
    chk(32'(exp_q.size()), 32'h0);
    $display("test window done");
    stop_test;
  end
endmodule : tb_byte_op_decode_execute
